// File: asr_pkg.sv
package asr_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	localparam int CNT_W = 3;

	// ----------------------------------------------------------------
	// timing, slower grade (also safe for the faster one)
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int READ_CYCLE_MIN_NS = 70;
	localparam int ACCESS_MAX_NS = 70;
	localparam int WRITE_PULSE_MIN_NS = 50;
	localparam int ADDR_TO_WRITE_END_NS = 60;
	localparam int DATA_SETUP_TO_WRITE_END_NS = 30;
	localparam int WRITE_TO_FLOAT_MAX_NS = 25;
	localparam int DISABLE_TO_FLOAT_MAX_NS = 25;
	localparam int DESELECT_TO_FLOAT_MAX_NS = 25;
	localparam int SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// derived cycle counts, minimums rounded up
	// ----------------------------------------------------------------
	localparam int ACCESS_CYC = (ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AW_CYC = (ADDR_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DWZ_NS = DATA_SETUP_TO_WRITE_END_NS + WRITE_TO_FLOAT_MAX_NS;
	localparam int DWZ_CYC = (DWZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_MAX1 = (WP_CYC > AW_CYC) ? WP_CYC : AW_CYC;
	localparam int WR_CYC = (WR_MAX1 > DWZ_CYC) ? WR_MAX1 : DWZ_CYC;
	localparam int RD_CYC = ACCESS_CYC + SYNC_STAGES;
	localparam int FLT_MAX = (DISABLE_TO_FLOAT_MAX_NS > DESELECT_TO_FLOAT_MAX_NS) ?
		DISABLE_TO_FLOAT_MAX_NS : DESELECT_TO_FLOAT_MAX_NS;
	localparam int GAP_CYC = (FLT_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CYC = (READ_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYC - 1);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ASR_IDLE = 3'h0,
		ASR_READ = 3'h1,
		ASR_WRITE = 3'h2,
		ASR_GAP = 3'h3,
		ASR_RETAIN = 3'h4,
		ASR_WAKE = 3'h5
	} asr_state_e;

	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] word_address;
		logic [DATA_W-1:0] wdata;
	} asr_req_s;

	typedef struct packed {
		logic [ADDR_W-1:0] word_address;
		logic cs_n;
		logic oe_n;
		logic we_n;
	} asr_pins_s;

endpackage

// File: asr_timer.sv
`timescale 1ns/1ps
module asr_timer #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic done
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = count;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done = (cnt_q == '0);

endmodule

// File: asr_host.sv
`timescale 1ns/1ps
// Behaviour
// - space accesses one cycle time apart
// - write only while select and write low
// - window closes at first rising strobe
// - keep write window open 50 ns
// - address stable 60 ns, held past window
// - data set up 30 ns, held past window
// - enable-low write needs longer window
// - never drive while device drives bus
module asr_host (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// user request
	input wire logic req_valid,
	input wire asr_pkg::asr_req_s req,
	output logic req_ready,
	// user response
	output logic rsp_valid,
	output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
	// data retention
	input wire logic retain_req,
	output logic retained,
	// memory pins
	output asr_pkg::asr_pins_s pins,
	output logic [asr_pkg::DATA_W-1:0] data_bus_out,
	output logic data_bus_oe,
	input wire logic [asr_pkg::DATA_W-1:0] data_bus_in
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	asr_pkg::asr_state_e state_q, state_d;
	asr_pkg::asr_pins_s pins_q, pins_d;
	logic [asr_pkg::DATA_W-1:0] dout_q, dout_d;
	logic doe_q, doe_d;
	logic ready_q, ready_d;
	logic rsp_q, rsp_d;
	logic [asr_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic retained_q, retained_d;
	logic [asr_pkg::DATA_W-1:0] sync1_q, sync2_q;
	logic tmr_load;
	logic [asr_pkg::CNT_W-1:0] tmr_count;
	logic tmr_done;
	logic take;

	asr_timer #(
		.W(asr_pkg::CNT_W)
	) u_timer (
		.clk(clk),
		.srst(srst),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	// ----------------------------------------------------------------
	// read data synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		sync1_q <= data_bus_in;
		sync2_q <= sync1_q;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign take = req_valid && ready_q;

	always_comb begin
		state_d = state_q;
		pins_d = pins_q;
		dout_d = dout_q;
		doe_d = doe_q;
		rsp_d = 1'b0;
		rdata_d = rdata_q;
		retained_d = retained_q;
		tmr_load = 1'b0;
		tmr_count = '0;
		unique case (state_q)
			asr_pkg::ASR_IDLE: begin
				if (take) begin
					pins_d.word_address = req.word_address;
					pins_d.cs_n = 1'b0;
					tmr_load = 1'b1;
					if (req.write) begin
						// enable stays high so the device never drives during the write
						pins_d.we_n = 1'b0;
						dout_d = req.wdata;
						doe_d = 1'b1;
						tmr_count = asr_pkg::WR_LOAD;
						state_d = asr_pkg::ASR_WRITE;
					end else begin
						pins_d.oe_n = 1'b0;
						tmr_count = asr_pkg::RD_LOAD;
						state_d = asr_pkg::ASR_READ;
					end
				end else if (retain_req) begin
					retained_d = 1'b1;
					state_d = asr_pkg::ASR_RETAIN;
				end
			end
			asr_pkg::ASR_READ: begin
				if (tmr_done) begin
					// sample only after access time plus synchroniser delay
					rdata_d = sync2_q;
					rsp_d = 1'b1;
					pins_d.cs_n = 1'b1;
					pins_d.oe_n = 1'b1;
					tmr_load = 1'b1;
					tmr_count = asr_pkg::GAP_LOAD;
					state_d = asr_pkg::ASR_GAP;
				end
			end
			asr_pkg::ASR_WRITE: begin
				if (tmr_done) begin
					// both strobes rise together; address and data held one more cycle
					pins_d.cs_n = 1'b1;
					pins_d.we_n = 1'b1;
					tmr_load = 1'b1;
					tmr_count = asr_pkg::GAP_LOAD;
					state_d = asr_pkg::ASR_GAP;
				end
			end
			asr_pkg::ASR_GAP: begin
				doe_d = 1'b0;
				if (tmr_done) begin
					state_d = asr_pkg::ASR_IDLE;
				end
			end
			asr_pkg::ASR_RETAIN: begin
				if (!retain_req) begin
					retained_d = 1'b0;
					tmr_load = 1'b1;
					tmr_count = asr_pkg::WAKE_LOAD;
					state_d = asr_pkg::ASR_WAKE;
				end
			end
			asr_pkg::ASR_WAKE: begin
				if (tmr_done) begin
					state_d = asr_pkg::ASR_IDLE;
				end
			end
			default: begin
				state_d = asr_pkg::ASR_IDLE;
			end
		endcase
		ready_d = (state_d == asr_pkg::ASR_IDLE) && !(state_q == asr_pkg::ASR_IDLE && take);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= asr_pkg::ASR_IDLE;
			pins_q <= '{word_address: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			dout_q <= '0;
			doe_q <= 1'b0;
			ready_q <= 1'b0;
			rsp_q <= 1'b0;
			rdata_q <= '0;
			retained_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pins_q <= pins_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
			ready_q <= ready_d;
			rsp_q <= rsp_d;
			rdata_q <= rdata_d;
			retained_q <= retained_d;
		end
	end

	assign pins = pins_q;
	assign data_bus_out = dout_q;
	assign data_bus_oe = doe_q;
	assign req_ready = ready_q;
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
	assign retained = retained_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence write_pulse_s;
		!pins_q.we_n [*2] ##1 pins_q.we_n;
	endsequence

	sequence read_pulse_s;
		!pins_q.oe_n [*4] ##1 pins_q.oe_n;
	endsequence

	reset_idle_a: assert property (disable iff (1'b0) srst |=> pins_q.cs_n && pins_q.oe_n && pins_q.we_n && !doe_q)
		else $error("strobes not idle after reset");
	write_select_a: assert property (!pins_q.we_n |-> !pins_q.cs_n && doe_q)
		else $error("write strobe without select or data");
	write_width_a: assert property ($fell(pins_q.we_n) |-> write_pulse_s)
		else $error("write window not two cycles");
	write_close_a: assert property ($rose(pins_q.we_n) |-> $rose(pins_q.cs_n))
		else $error("write window not closed by both strobes");
	addr_hold_a: assert property (!$past(pins_q.we_n) |-> $stable(pins_q.word_address))
		else $error("address moved during or at end of write");
	data_hold_a: assert property ($rose(pins_q.we_n) |-> doe_q && $stable(dout_q) ##1 !doe_q)
		else $error("write data not held past window");
	no_contend_a: assert property (doe_q |-> pins_q.oe_n)
		else $error("bus driven while device enabled");
	read_sample_a: assert property ($fell(pins_q.oe_n) |-> read_pulse_s and ##4 rsp_q)
		else $error("read sampled early");
	access_gap_a: assert property ($rose(pins_q.cs_n) |-> pins_q.cs_n [*2])
		else $error("accesses too close");
	wake_gap_a: assert property ($fell(retained_q) |-> pins_q.cs_n [*3])
		else $error("access too soon after retention");

endmodule

// File: asr_sram_model.sv
`timescale 1ns/1ps
module asr_sram_model #(
	parameter int ACC_NS = 70
) (
	// memory pins
	input wire asr_pkg::asr_pins_s pins,
	input wire logic [asr_pkg::DATA_W-1:0] host_data,
	input wire logic host_oe,
	// resolved bus and contention flag
	output logic [asr_pkg::DATA_W-1:0] bus,
	output logic clash
);
	// ----------------------------------------------------------------
	// storage and mode decode
	// ----------------------------------------------------------------
	logic [asr_pkg::DATA_W-1:0] mem [logic [asr_pkg::ADDR_W-1:0]];
	logic [asr_pkg::DATA_W-1:0] last = 8'h00;
	logic rd_ok = 1'b0;
	wire logic rd_mode = !pins.cs_n && !pins.oe_n && pins.we_n;
	wire logic wr_win = !pins.cs_n && !pins.we_n;
	// data only after the full access time, released at once
	always @(rd_mode or pins.word_address) begin
		rd_ok = 1'b0;
		if (rd_mode) begin
			#(ACC_NS);
			rd_ok = rd_mode;
		end
	end
	// store at the first rising strobe
	always @(negedge wr_win) begin
		if (host_oe === 1'b1) mem[pins.word_address] = host_data;
	end
	// unwritten places read as the inverted low address byte
	always @(host_oe or host_data or rd_ok or last) begin
		if (host_oe) bus = host_data;
		else if (rd_ok) bus = mem.exists(pins.word_address) ? mem[pins.word_address] : ~pins.word_address[7:0];
		else bus = ~last; // floating bus shows the inverse of the last driven value
	end
	always @(bus) if (host_oe || rd_ok) last = bus;
	assign clash = host_oe && rd_ok;
endmodule

// File: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	asr_pkg::asr_req_s req = '0;
	logic retain_req = 1'b0;
	logic req_ready, rsp_valid, retained, data_bus_oe, clash;
	logic [asr_pkg::DATA_W-1:0] rsp_rdata, data_bus_out, bus;
	asr_pkg::asr_pins_s pins;
	logic [asr_pkg::DATA_W-1:0] ref_mem [logic [asr_pkg::ADDR_W-1:0]];
	int error_cnt = 0;
	int num_checks = 0;
	int low_cnt = 0;
	always #20 clk = ~clk;
	asr_host dut_u (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_req(retain_req), .retained(retained),
		.pins(pins), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(bus));
	asr_sram_model #(.ACC_NS(70)) mem_u (.pins(pins), .host_data(data_bus_out), .host_oe(data_bus_oe),
		.bus(bus), .clash(clash));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] exp_rd(input logic [18:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : ~a[7:0];
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req <= '{wr, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		`CHK(req_ready, 1'b1)
		req_valid <= 1'b0;
		@(posedge clk);
		if (wr) begin
			`CHK({pins.cs_n, pins.oe_n, pins.we_n, data_bus_oe, data_bus_out}, {4'b0101, d})
			@(posedge clk);
			`CHK({pins.we_n, data_bus_oe, data_bus_out}, {2'b01, d})
			@(posedge clk);
			`CHK({pins.cs_n, pins.we_n, data_bus_oe}, 3'b111)
			ref_mem[a] = d;
		end else begin
			`CHK({pins.cs_n, pins.oe_n, pins.we_n, data_bus_oe}, 4'b0010)
			repeat (4) @(posedge clk);
			`CHK({rsp_valid, rsp_rdata}, {1'b1, exp_rd(a)})
		end
		`CHK(pins.word_address, a)
	endtask
	// ----------------------------------------------------------------
	// pin monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (!srst) begin
			`CHK(clash, 1'b0)
			low_cnt = pins.cs_n ? 0 : low_cnt + 1;
			`CHK(low_cnt <= 4, 1'b1)
			if (req_ready) `CHK({pins.cs_n, pins.oe_n, pins.we_n}, 3'b111)
		end
	end
	initial begin
		#(40 * 20000);
		error_cnt++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		void'($urandom(48));
		repeat (6) @(posedge clk);
		`CHK({pins.cs_n, pins.oe_n, pins.we_n, data_bus_oe}, 4'b1110)
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		access(1'b1, 19'h00000, 8'ha5);
		access(1'b1, 19'h7ffff, 8'h5a);
		access(1'b0, 19'h00000, 8'h00);
		access(1'b0, 19'h7ffff, 8'h00);
		access(1'b0, 19'h12345, 8'h00);
		for (int i = 0; i < 80; i++) begin
			access(1'($urandom), 19'h40000 | 19'($urandom % 32), 8'($urandom));
		end
		// retention holds requests off, then a wake gap
		retain_req <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK({retained, req_ready, pins.cs_n}, 3'b101)
		req_valid <= 1'b1;
		req <= '{1'b0, 19'h00000, 8'h00};
		repeat (3) @(posedge clk);
		`CHK(req_ready, 1'b0)
		retain_req <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pins.cs_n === 1'b1 && n < 20);
		`CHK(pins.cs_n, 1'b0)
		req_valid <= 1'b0;
		`CHK(n >= 4, 1'b1)
		repeat (4) @(posedge clk);
		`CHK({rsp_valid, rsp_rdata}, {1'b1, exp_rd(19'h00000)})
		// a read cut by reset, then a read racing a retention request
		req <= '{1'b0, 19'h00000, 8'h00};
		req_valid <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b1;
		req_valid <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({pins.cs_n, pins.oe_n, pins.we_n, data_bus_oe, req_ready, rsp_valid}, 6'b111000)
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		retain_req <= 1'b1;
		access(1'b0, 19'h7ffff, 8'h00);
		`CHK(retained, 1'b0)
		retain_req <= 1'b0;
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule
